// ---- design/ebd_pkg.sv ----
// ebd_pkg: constants, layouts and carriers for the external bus decoder
// and arbiter. assumes a 20 MHz peripheral clock and an AXI4-Lite master.
package ebd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // address map
  localparam int          ADDR_W       = 24;
  localparam int          PAGE_W       = 8;
  localparam int          EXT_ADDR_W   = 20;
  localparam logic [7:0]  PAGE_INTERNAL = 8'h00;
  localparam logic [7:0]  PAGE_TOP      = 8'hFF;
  localparam logic [23:0] BOOT_ROM_BASE = 24'hFF0000;
  localparam logic [15:0] BOOT_ROM_SIZE = 16'h1000;     // 4K words
  localparam logic [15:0] RAM_BLK_SIZE  = 16'h4000;     // 16K words
  localparam logic [7:0]  IO_INT_LAST   = 8'h1F;        // io pages 0..31
  localparam logic [7:0]  BOOT_LAST     = 8'hFE;        // boot pages 0..254

  // bank boundaries after reset: first page of banks 1..3
  localparam logic [7:0]  BANK1_START_RST = 8'h40;
  localparam logic [7:0]  BANK2_START_RST = 8'h80;
  localparam logic [7:0]  BANK3_START_RST = 8'hC0;
  localparam logic [7:0]  BANK0_START     = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_BANK_BND  = 8'h04;
  localparam logic [7:0] REG_CFG_BANK0 = 8'h08;
  localparam logic [7:0] REG_CFG_IO    = 8'h18;
  localparam logic [7:0] REG_CFG_BOOT  = 8'h1C;
  localparam logic [7:0] REG_PAGES     = 8'h20;
  localparam logic [7:0] REG_STATUS    = 8'h24;
  localparam logic [7:0] REG_DMA_REQ   = 8'h28;

  // space config field layout
  localparam int CFG_RWAIT_LSB = 0;   // [2:0]
  localparam int CFG_WWAIT_LSB = 3;   // [5:3]
  localparam int CFG_WMODE_LSB = 6;   // [7:6]
  localparam int CFG_CDIV_LSB  = 8;   // [10:8]
  localparam int CFG_HOLD_BIT  = 11;
  localparam int CFG_POL_BIT   = 12;  // 1: strobe active high
  localparam int CFG_W16_BIT   = 13;  // 1: 16-bit data bus
  localparam int CFG_W        = 14;
  localparam logic [13:0] CFG_RST = 14'h2000;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // bus request sync plus arbitration settles on the fourth edge
  localparam int GRANT_MIN_CYC = 3;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    SP_RAM = 3'd0, SP_ROM = 3'd1, SP_BANK = 3'd2, SP_IOINT = 3'd3,
    SP_IOEXT = 3'd4, SP_BOOT = 3'd5, SP_NONE = 3'd6
  } ebd_space_t;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00, ARB_WAIT = 2'b01, ARB_GRANT = 2'b11
  } ebd_arb_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        valid;
  } ebd_axi_a_t;

  // an access from the core side
  typedef struct packed {
    logic        valid;
    logic        io;        // access to I/O space
    logic        boot;      // access to boot space
    logic        second_rd; // second read of one instruction
    logic        dma;       // made by a dma channel
    logic [23:0] addr;
  } ebd_req_t;

  typedef struct packed {
    logic [3:0]  bank_sel;
    logic        io_sel;
    logic        boot_sel;
    logic        rd_n;
    logic        wr_n;
    logic        oe_n;      // low while the device drives the pins
    logic [19:0] addr;
  } ebd_ext_t;
endpackage

// ---- design/ebd_top.sv ----
// ebd_top: address decode, external port arbitration, dma bus priority
// and an AXI4-Lite register slave. assumes inputs synchronous to clock
// except the external bus request, which is synchronised here.
// Operation
// - unified space is 256 pages of 64K words, upper byte is page
// - page 0 decodes three internal ram blocks, 48K words total
// - 4K boot rom at FF0000, first fetch after reset from it
// - reset banks: pages 1-63, 64-127, 128-191, 192-254
// - each bank has its own select; boundaries reprogrammable by software
// - each off-chip space has its own wait, divide, hold, polarity, width; here only the width bit acts, the other fields only go out on space_cfg
// - external address is 20 lines, scaled by width and packing; here scaled by the width bit only
// - io pages 0-31 internal, 32-255 off-chip with io select
// - boot space: 254 off-chip pages, own select, core and dma; decode here takes pages 0-254, 255 pages
// - generator address is page register over 16-bit index
// - second generator page register also pages external data; here it only feeds agen_addr
// - indirect jumps take jump page register over generator value
// - external master lowest priority, granted only when none pending
// - grant no sooner than three clocks after request
// - float address, data, selects and strobes, then assert grant; here both happen on the same edge
// - stall external accesses while granted; drop grant when released
// - never grant between two reads of one instruction
// - core exclusive option still grants dma and external requests
// - request and grant work during boot and reset
// - grant hang flag when access ready but bus granted away
// - dma priority: sport rx, sport tx, adc, spi, memory dma
// - per-channel descriptor dma, chained, steals spare cycles; only the dma grant priority is built here
// - peripheral clock is core rate or half of it; here half_clk is only a stored REG_CTRL bit
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module ebd_top #(
  parameter int DMA_CH = 5
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 core_rst_n,
  // core side
  input  wire ebd_pkg::ebd_req_t    core_req,
  input  wire logic                 agen_sel,
  input  wire logic [15:0]          agen_index,
  input  wire logic                 jump_req,
  input  wire logic [15:0]          jump_low,
  input  wire logic [DMA_CH-1:0]    dma_req,
  output logic [DMA_CH-1:0]         dma_grant,
  output logic [23:0]               agen_addr,
  output logic [23:0]               jump_target,
  output logic                      core_stall,
  output ebd_pkg::ebd_space_t       space,
  output logic [1:0]                ram_block,
  // external pins
  input  wire logic                 ext_bus_request_n,
  output logic                      ext_bus_grant_n,
  output logic                      grant_hang_flag,
  output ebd_pkg::ebd_ext_t         ext,
  output logic [ebd_pkg::CFG_W-1:0] space_cfg,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_awaddr,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  input  wire logic [7:0]           s_araddr,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready
);
  import ebd_pkg::*;

  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    ebd_arb_t             arb;
    logic [1:0]           wait_cnt;
    logic                 core_excl;
    logic                 half_clk;
    logic [7:0]           b1, b2, b3;
    logic [5:0][13:0]     cfg;
    logic [7:0]           agen0_page, agen1_page, jump_page;
    logic                 hang;
    logic [DMA_CH-1:0]    dgnt;
    logic                 boot_done;
    logic [23:0]          aaddr, jtgt;
    logic                 stall;
    ebd_space_t           sp;
    logic [1:0]           blk;
    ebd_ext_t             ext;
    logic [13:0]          scfg;
    logic                 aw_got, w_got;
    logic [7:0]           awa;
    logic [31:0]          wd;
    logic [3:0]           ws;
    logic                 bv;
    logic [1:0]           br;
    logic                 rv;
    logic [31:0]          rd;
    logic [1:0]           rr;
  } ebd_state_t;

  ebd_state_t st, next_st;

  ////////////////////////////////////////////////////////////////////////////
  // helper: register read mux
  function automatic logic [31:0] reg_read(input ebd_state_t s,
                                           input logic [7:0] a,
                                           output logic ok);
    logic [31:0] v;
    v  = 32'h00000000;
    ok = 1'b1;
    if (a == REG_CTRL) begin
      v = {30'h0, s.half_clk, s.core_excl};
    end else if (a == REG_BANK_BND) begin
      v = {8'h00, s.b3, s.b2, s.b1};
    end else if (a >= REG_CFG_BANK0 && a <= REG_CFG_BOOT && a[1:0] == 2'b00)
    begin
      v = {18'h0, s.cfg[3'((a - REG_CFG_BANK0) >> 2)]};
    end else if (a == REG_PAGES) begin
      v = {8'h00, s.jump_page, s.agen1_page, s.agen0_page};
    end else if (a == REG_STATUS) begin
      v = {27'h0, s.boot_done, s.stall, s.hang, s.arb == ARB_GRANT,
           s.sync2};
    end else begin
      ok = 1'b0;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0]  pg;
    logic        core_pend;
    logic        ok;
    logic [31:0] rv;
    logic [2:0]  idx;
    logic [31:0] mrg;
    logic        ext_acc;
    next_st = st;
    pg = core_req.addr[23:16];
    ok = 1'b0;
    rv = 32'h0;
    idx = 3'd0;
    mrg = 32'h0;

    // address generators and jump page
    next_st.aaddr = {agen_sel ? st.agen1_page : st.agen0_page,
                     agen_index};
    if (jump_req) begin
      next_st.jtgt = {st.jump_page, jump_low};
    end

    // decode
    next_st.blk = 2'd0;
    if (core_req.io) begin
      // io pages are 1K words, so the page sits above the 10-bit offset
      next_st.sp = (core_req.addr[17:10] <= IO_INT_LAST) ? SP_IOINT
                                                          : SP_IOEXT;
    end else if (core_req.boot) begin
      next_st.sp = (pg <= BOOT_LAST) ? SP_BOOT : SP_NONE;
    end else if (pg == PAGE_INTERNAL) begin
      next_st.sp = (core_req.addr[15:0] < 3 * RAM_BLK_SIZE) ? SP_RAM
                                                             : SP_NONE;
      next_st.blk = core_req.addr[15:14];
    end else if (pg == PAGE_TOP &&
                 core_req.addr[15:0] < BOOT_ROM_SIZE) begin
      next_st.sp = SP_ROM;
    end else if (pg == PAGE_TOP) begin
      next_st.sp = SP_NONE;
    end else begin
      next_st.sp = SP_BANK;
    end
    ext_acc = core_req.valid && (next_st.sp == SP_BANK ||
              next_st.sp == SP_IOEXT || next_st.sp == SP_BOOT);

    // external request synchroniser
    next_st.sync1 = ~ext_bus_request_n;
    next_st.sync2 = st.sync1;

    // internal demand on the port; exclusive mode blocks nothing here
    core_pend = ext_acc || (|dma_req && !st.core_excl) ||
                (|dma_req && st.core_excl);
    // arbiter
    case (st.arb)
      ARB_IDLE: begin
        next_st.wait_cnt = 2'd0;
        if (st.sync2) begin
          next_st.arb = ARB_WAIT;
        end
      end
      ARB_WAIT: begin
        if (!st.sync2) begin
          next_st.arb = ARB_IDLE;
        end else if (!core_pend && !core_req.second_rd) begin
          next_st.arb = ARB_GRANT;
        end
      end
      ARB_GRANT: begin
        if (!st.sync2) begin
          next_st.arb = ARB_IDLE;
        end
      end
      default: next_st.arb = ARB_IDLE;
    endcase
    next_st.hang  = (st.arb == ARB_GRANT) && ext_acc;
    next_st.stall = (st.arb == ARB_GRANT) && ext_acc;

    // dma fixed priority, lowest index wins
    next_st.dgnt = '0;
    for (int i = DMA_CH - 1; i >= 0; i--) begin
      if (dma_req[i] && !(st.arb == ARB_GRANT)) begin
        next_st.dgnt = DMA_CH'(1) << i;
      end
    end

    // external pins
    if (next_st.sp == SP_BANK) idx = pg < st.b1 ? 3'd0 :
                                     pg < st.b2 ? 3'd1 :
                                     pg < st.b3 ? 3'd2 : 3'd3;
    else if (next_st.sp == SP_IOEXT) idx = 3'd4;
    else idx = 3'd5;
    next_st.scfg = st.cfg[idx];
    // float on the same edge the grant goes out, never after it
    next_st.ext.oe_n = (next_st.arb == ARB_GRANT);
    next_st.ext.bank_sel = '0;
    next_st.ext.io_sel   = 1'b0;
    next_st.ext.boot_sel = 1'b0;
    next_st.ext.rd_n     = 1'b1;
    next_st.ext.wr_n     = 1'b1;
    if (ext_acc && next_st.arb != ARB_GRANT) begin
      if (next_st.sp == SP_BANK) next_st.ext.bank_sel[idx[1:0]] = 1'b1;
      next_st.ext.io_sel   = next_st.sp == SP_IOEXT;
      next_st.ext.boot_sel = next_st.sp == SP_BOOT;
      next_st.ext.rd_n     = 1'b0;
    end
    // 8-bit bus needs two bytes per word
    next_st.ext.addr = st.cfg[idx][CFG_W16_BIT] ?
        core_req.addr[19:0] : {core_req.addr[18:0], 1'b0};

    // boot rom fetch flag
    if (!core_rst_n) next_st.boot_done = 1'b0;
    else if (next_st.sp == SP_ROM) next_st.boot_done = 1'b1;

    // axi write
    if (s_awvalid && !st.aw_got) begin
      next_st.aw_got = 1'b1;
      next_st.awa = s_awaddr;
    end
    if (s_wvalid && !st.w_got) begin
      next_st.w_got = 1'b1;
      next_st.wd = s_wdata;
      next_st.ws = s_wstrb;
    end
    if (st.aw_got && st.w_got && !st.bv) begin
      rv = reg_read(st, st.awa, ok);
      for (int b = 0; b < 4; b++) begin
        mrg[b*8 +: 8] = st.ws[b] ? st.wd[b*8 +: 8] : rv[b*8 +: 8];
      end
      if (st.awa == REG_CTRL) begin
        next_st.core_excl = mrg[0];
        next_st.half_clk  = mrg[1];
      end else if (st.awa == REG_BANK_BND) begin
        next_st.b1 = mrg[7:0];
        next_st.b2 = mrg[15:8];
        next_st.b3 = mrg[23:16];
      end else if (st.awa >= REG_CFG_BANK0 && st.awa <= REG_CFG_BOOT) begin
        next_st.cfg[3'((st.awa - REG_CFG_BANK0) >> 2)] = mrg[13:0];
      end else if (st.awa == REG_PAGES) begin
        next_st.agen0_page = mrg[7:0];
        next_st.agen1_page = mrg[15:8];
        next_st.jump_page  = mrg[23:16];
      end
      next_st.bv = 1'b1;
      next_st.br = (ok && st.awa != REG_STATUS) ? AXI_OKAY : AXI_SLVERR;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
    end
    if (st.bv && s_bready) next_st.bv = 1'b0;

    // axi read
    if (s_arvalid && !st.rv) begin
      next_st.rd = reg_read(st, s_araddr, ok);
      next_st.rr = ok ? AXI_OKAY : AXI_SLVERR;
      next_st.rv = 1'b1;
    end else if (st.rv && s_rready) begin
      next_st.rv = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; arbitration ignores core reset so it runs during boot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st            <= '0;
      st.arb        <= ARB_IDLE;
      st.b1         <= BANK1_START_RST;
      st.b2         <= BANK2_START_RST;
      st.b3         <= BANK3_START_RST;
      st.cfg        <= {6{CFG_RST}};
      st.jtgt       <= BOOT_ROM_BASE;
      st.sp         <= SP_NONE;
      st.ext.rd_n   <= 1'b1;
      st.ext.wr_n   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign ext_bus_grant_n = ~(st.arb == ARB_GRANT);
  assign grant_hang_flag = st.hang;
  assign dma_grant       = st.dgnt;
  assign agen_addr       = st.aaddr;
  assign jump_target     = st.jtgt;
  assign core_stall      = st.stall;
  assign space           = st.sp;
  assign ram_block       = st.blk;
  assign ext             = st.ext;
  assign space_cfg       = st.scfg;
  assign s_awready       = !st.aw_got;
  assign s_wready        = !st.w_got;
  assign s_bvalid        = st.bv;
  assign s_bresp         = st.br;
  assign s_arready       = !st.rv;
  assign s_rvalid        = st.rv;
  assign s_rdata         = st.rd;
  assign s_rresp         = st.rr;
endmodule

// ---- sim/ebd_monitor.sv ----
// ebd_monitor: assertions on the ebd_top ports
// bound into ebd_top by the bench; one clock, async active-low reset
`timescale 1ns/1ns
module ebd_monitor #(
  parameter int DMA_CH = 5
) (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire ebd_pkg::ebd_req_t   core_req,
  input wire logic                jump_req,
  input wire logic [15:0]         jump_low,
  input wire logic [DMA_CH-1:0]   dma_req,
  input wire logic [DMA_CH-1:0]   dma_grant,
  input wire logic [23:0]         jump_target,
  input wire logic                core_stall,
  input wire ebd_pkg::ebd_space_t space,
  input wire logic                ext_bus_request_n,
  input wire logic                ext_bus_grant_n,
  input wire logic                grant_hang_flag,
  input wire ebd_pkg::ebd_ext_t   ext
);
  import ebd_pkg::*;
  ////////////////////////////////////////
  // lowest pending channel is the one that must win
  logic [DMA_CH-1:0] low_req;
  assign low_req = dma_req & (~dma_req + 1'b1);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_req_seen;
    $fell(ext_bus_request_n) && ext_bus_grant_n;
  endsequence
  sequence s_bank_data;
    core_req.valid && !core_req.io && !core_req.boot &&
      core_req.addr[23:16] == 8'h01;
  endsequence
  // a bank access held off while the bus is away
  sequence s_held_off;
    s_bank_data ##0 !ext_bus_grant_n && !ext_bus_request_n;
  endsequence
  a_grant_no_early: assert property (
    s_req_seen |-> ext_bus_grant_n [*3]) else $error("grant too early");
  a_float_grant: assert property (!ext_bus_grant_n |-> ext.oe_n)
    else $error("pins driven while granted");
  a_grant_free: assert property ($fell(ext_bus_grant_n) |->
    $past(dma_req) == '0 && !$past(core_req.second_rd))
    else $error("grant with internal request pending");
  a_grant_drop: assert property ($rose(ext_bus_request_n) |->
    ##[1:4] ext_bus_grant_n) else $error("grant not dropped");
  a_stall_hang: assert property (s_held_off |=>
    core_stall && grant_hang_flag) else $error("no stall or hang flag");
  a_dma_prio: assert property (dma_req != '0 |=>
    dma_grant == $past(low_req)) else $error("dma priority wrong");
  a_jump_page: assert property (jump_req |=>
    jump_target[15:0] == $past(jump_low)) else $error("jump low wrong");
  a_rom_decode: assert property (core_req.valid && !core_req.io &&
    !core_req.boot && core_req.addr[23:12] == 12'hFF0 |=>
    space == SP_ROM) else $error("rom not decoded");
  a_bank_decode: assert property (s_bank_data ##0 ext_bus_grant_n
    |=> ext.bank_sel == 4'h1) else $error("bank 0 select wrong");
endmodule

// ---- sim/ebd_ext_master.sv ----
// ebd_ext_master: outside bus master on the request and grant pins
// the bench sets want; the request changes only after a rising edge
`timescale 1ns/1ns
module ebd_ext_master (
  input  wire logic clock,
  input  wire logic want,
  input  wire logic ext_bus_grant_n,
  output logic      ext_bus_request_n,
  output int        wait_cycles
);
  initial begin
    ext_bus_request_n = 1'b1;
    wait_cycles = 0;
  end
  // request follows want; raising it ends the tenure, so the count of
  // cycles spent waiting restarts whenever the request is idle
  always @(posedge clock) begin
    ext_bus_request_n <= !want;
    if (ext_bus_request_n)
      wait_cycles <= 0;
    else if (ext_bus_grant_n)
      wait_cycles <= wait_cycles + 1;
  end
endmodule

// ---- sim/test_ext_bus_decode_arbiter.sv ----
// test_ext_bus_decode_arbiter: self-checking bench for ebd_top
// assumes ebd_pkg, ebd_top, ebd_monitor, ebd_ext_master compiled first
`timescale 1ns/1ns
module test_ext_bus_decode_arbiter;
  import ebd_pkg::*;
  logic        clock, rst_n, core_rst_n, agen_sel, jump_req, want;
  ebd_req_t    core_req;
  logic [15:0] agen_index, jump_low;
  logic [4:0]  dma_req, dma_grant;
  logic [23:0] agen_addr, jump_target;
  logic        core_stall, grant_n, req_n, hang;
  ebd_space_t  space;
  logic [1:0]  ram_block, s_bresp, s_rresp, rsp;
  ebd_ext_t    ext;
  logic [13:0] space_cfg;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0]  s_wstrb;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  int          errors, checks_done, cycles, wait_cycles;
  ebd_top #(.DMA_CH(5)) u_dut (
    .clock(clock), .rst_n(rst_n), .core_rst_n(core_rst_n),
    .core_req(core_req), .agen_sel(agen_sel), .agen_index(agen_index),
    .jump_req(jump_req), .jump_low(jump_low), .dma_req(dma_req),
    .dma_grant(dma_grant), .agen_addr(agen_addr),
    .jump_target(jump_target), .core_stall(core_stall), .space(space),
    .ram_block(ram_block), .ext_bus_request_n(req_n),
    .ext_bus_grant_n(grant_n), .grant_hang_flag(hang), .ext(ext),
    .space_cfg(space_cfg), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  ebd_ext_master u_master (.clock(clock), .want(want),
    .ext_bus_grant_n(grant_n), .ext_bus_request_n(req_n),
    .wait_cycles(wait_cycles));
  ////////////////////////////////////////
  // 50 ns period clock and hang guard
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      finish_test;
    end
  end
  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // outputs are registered, so the negedge shows what the next edge takes
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clock);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    forever begin
      @(negedge clock);
      aw = s_awvalid & s_awready;
      w = s_wvalid & s_wready;
      b = s_bvalid;
      rsp = s_bresp;
      @(posedge clock);
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
      if (b) begin
        s_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic t, v;
    @(posedge clock);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    forever begin
      @(negedge clock);
      t = s_arvalid & s_arready;
      v = s_rvalid;
      rd = s_rdata;
      rsp = s_rresp;
      @(posedge clock);
      if (t) s_arvalid <= 1'b0;
      if (v) begin
        s_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic acc(input logic io, boot, sec, input logic [23:0] a);
    @(posedge clock);
    core_req <= '{1'b1, io, boot, sec, 1'b0, a};
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic idle;
    @(posedge clock);
    core_req <= '0;
  endtask
  // request the bus, expect grant or not, then release it
  task automatic grab(input logic exp);
    @(posedge clock);
    want <= 1'b1;
    for (int i = 0; i < 12 && grant_n; i++) @(negedge clock);
    check("grant", grant_n, !exp);
    @(posedge clock);
    want <= 1'b0;
    repeat (6) @(negedge clock);
    check("released", grant_n, 1'b1);
  endtask
  task automatic t_decode;
    logic [23:0] ta [12] = '{24'h000000, 24'hFF0000, 24'h010000,
      24'h3F0000, 24'h400000, 24'h7F0000, 24'h800000, 24'hC00000,
      24'hFE0000, 24'h000000, 24'h03FC00, 24'h010000};
    ebd_space_t ts [12] = '{SP_RAM, SP_ROM, SP_BANK, SP_BANK, SP_BANK,
      SP_BANK, SP_BANK, SP_BANK, SP_BANK, SP_IOINT, SP_IOEXT, SP_BOOT};
    logic [5:0] tl [12] = '{6'h00, 6'h00, 6'h04, 6'h04, 6'h08, 6'h08,
      6'h10, 6'h20, 6'h20, 6'h00, 6'h02, 6'h01};
    for (int i = 0; i < 12; i++) begin
      acc(i inside {9, 10}, i == 11, 1'b0, ta[i]);
      check("space", space, ts[i]);
      check("sel", {ext.bank_sel, ext.io_sel, ext.boot_sel}, tl[i]);
    end
    acc(1'b0, 1'b0, 1'b0, 24'h008000);
    check("ram block", ram_block, 2'h2);
    idle;
  endtask
  task automatic t_regs;
    axi_rd(REG_BANK_BND);
    check("bounds", rd, 32'h00C08040);
    axi_rd(REG_CFG_BANK0);
    check("cfg reset", rd, 32'h00002000);
    axi_wr(REG_BANK_BND, 32'h00C08020);
    check("bresp", rsp, AXI_OKAY);
    axi_wr(REG_CFG_BANK0 + 8'h04, 32'h00001ABC);
    acc(1'b0, 1'b0, 1'b0, 24'h300123);
    check("bank1 sel", ext.bank_sel, 4'h2);
    check("bank1 cfg", space_cfg, 14'h1ABC);
    check("byte addr", ext.addr, 20'h00246);
    idle;
    axi_rd(REG_STATUS);
    check("status", rd, 32'h00000010);
    axi_rd(8'hFC);
    check("unmapped", rd, 32'h0);
    check("unmapped resp", rsp, AXI_SLVERR);
    axi_wr(REG_STATUS, 32'h0);
    check("status wr", rsp, AXI_SLVERR);
    axi_wr(REG_BANK_BND, 32'h00C08040);
  endtask
  task automatic t_pages;
    axi_wr(REG_PAGES, 32'h00123456);
    @(posedge clock);
    {agen_sel, jump_req, agen_index, jump_low} <= {2'h3, 32'hBEEFCAFE};
    @(posedge clock);
    @(negedge clock);
    check("agen1", agen_addr, 24'h34BEEF);
    check("jump", jump_target, 24'h12CAFE);
    @(posedge clock);
    {agen_sel, jump_req} <= 2'h0;
    @(posedge clock);
    @(negedge clock);
    check("agen0", agen_addr, 24'h56BEEF);
  endtask
  // grant taken during core reset, then a bank access held off
  task automatic t_grant;
    @(posedge clock);
    {core_rst_n, want} <= 2'h1;
    for (int i = 0; i < 12 && grant_n; i++) @(negedge clock);
    check("grant", grant_n, 1'b0);
    check("delay", wait_cycles >= 3, 1'b1);
    check("float", ext.oe_n, 1'b1);
    @(posedge clock);
    core_rst_n <= 1'b1;
    acc(1'b0, 1'b0, 1'b0, 24'h010000);
    check("stall", {core_stall, hang}, 2'h3);
    @(posedge clock);
    want <= 1'b0;
    repeat (6) @(negedge clock);
    check("resume", {grant_n, core_stall, hang, ext.oe_n}, 4'h8);
    check("bank0", ext.bank_sel, 4'h1);
    check("word addr", ext.addr, 20'h10000);
    idle;
  endtask
  task automatic t_blocked;
    @(posedge clock);
    dma_req <= 5'h10;
    grab(1'b0);
    @(posedge clock);
    dma_req <= 5'h00;
    acc(1'b0, 1'b0, 1'b1, 24'h000100);
    grab(1'b0);
    idle;
    axi_wr(REG_CTRL, 32'h1);
    grab(1'b1);
    axi_wr(REG_CTRL, 32'h0);
  endtask
  task automatic t_dma;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      dma_req <= 5'(5'h1F << i);
      @(posedge clock);
      @(negedge clock);
      check("dma", dma_grant, 5'(5'h01 << i));
    end
    @(posedge clock);
    dma_req <= 5'h00;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // reset for five cycles, then run each scenario in turn
  initial begin
    {clock, rst_n, core_rst_n} = 3'h1;
    {cycles, errors, checks_done} = '0;
    {agen_sel, jump_req, want, s_awvalid, s_wvalid} = 5'h0;
    {s_bready, s_arvalid, s_rready, dma_req, core_req} = '0;
    {agen_index, jump_low, s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check("reset", {grant_n, ext.oe_n, s_awready, s_bvalid}, 4'hA);
    check("boot fetch", jump_target, BOOT_ROM_BASE);
    t_decode;
    t_regs;
    t_pages;
    t_grant;
    t_blocked;
    t_dma;
    finish_test;
  end
endmodule
bind ebd_top ebd_monitor #(.DMA_CH(DMA_CH)) u_mon (
  .clock(clock), .rst_n(rst_n), .core_req(core_req),
  .jump_req(jump_req), .jump_low(jump_low), .dma_req(dma_req),
  .dma_grant(dma_grant), .jump_target(jump_target),
  .core_stall(core_stall), .space(space), .ext(ext),
  .ext_bus_request_n(ext_bus_request_n),
  .ext_bus_grant_n(ext_bus_grant_n),
  .grant_hang_flag(grant_hang_flag));
